//--- verilog/reset_config_loader.sv
// Function
// - Start sequence on reset release, test mode off.
// - Outputs tristated, GPIOs inputs, port silent.
// - Load info block, calibrate APLL first.
// - Capture GPIO straps on reset release.
// - Build default image without touching pins.
// - Strap selects port protocol, SPI 4-wire.
// - Scan EEPROM updates, restart when applied.
// - Load strap-numbered memory config, report result.
// - Config overwrites only its listed registers.
// - Divider set means background APLL recalibration.
// - Memory config registers reselect serial port protocol.
// - Probe blocks only at two fixed offsets.
// - Skip bad blocks, continue, then hotfix.
// - Load first valid EEPROM block, stop.
// - Load and run memory hotfix after search.
// - Relock if config loaded, commit, enable outputs, monitors, alarms.
// - Reach operation anyway, report failure bits.
// - Probe addresses at three speeds, else absent.
// - Skip EEPROM search when strapped SPI.
// - Number from selected straps, lowest LSB.

`include "reset_config_defs.svh"

module reset_config_loader
  import reset_config_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic master_reset_n,
  input wire logic test_mode_n,
  input wire logic [`GPIO_W-1:0] gpio_in,
  output logic otp_req,
  output logic [1:0] otp_op,
  output logic [`CFG_NUM_W-1:0] otp_cfg_num,
  input wire logic otp_done,
  input wire logic otp_found,
  input wire logic otp_csum_ok,
  input wire logic otp_sets_fbdiv,
  input wire logic otp_sel_spi,
  input wire logic otp_sel_4wire,
  input wire logic [`GPIO_W-1:0] info_sel_mask,
  input wire logic [`IDX_W-1:0] info_spi_idx,
  input wire logic [`IDX_W-1:0] info_scan_idx,
  output logic apll_cal_req,
  input wire logic apll_done,
  output logic image_init_req,
  input wire logic image_init_done,
  output logic commit_req,
  input wire logic commit_done,
  output logic clock_outputs_oe,
  output logic clock_outputs_inv_oe,
  output logic gpio_out_en,
  output logic serial_en,
  output logic serial_spi_mode,
  output logic serial_spi_4wire,
  output logic monitors_en,
  output logic alarms_en,
  output logic seq_busy,
  output logic otp_cfg_err,
  output logic otp_cfg_loaded,
  output logic [`CFG_NUM_W-1:0] otp_cfg_loaded_num,
  output logic eeprom_absent,
  output logic eeprom_cfg_loaded,
  output logic eeprom_update_applied,
  input wire logic link_clk,
  output logic i2c_req,
  output logic [1:0] i2c_kind,
  output logic [6:0] i2c_addr,
  output logic [1:0] i2c_speed,
  output logic [15:0] i2c_offset,
  input wire logic i2c_done,
  input wire logic i2c_ack,
  input wire logic i2c_valid
);

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    seq_state_e state;
    logic mr_s1, mr_s2, mr_s3, tm_s1, tm_s2;
    logic [`GPIO_W-1:0] gpio_s1, gpio_s2, straps, sel_mask;
    logic [`IDX_W-1:0] spi_idx, scan_idx;
    logic done_s1, done_s2, done_s3, start_tgl, ee_mode, edge_seen;
    logic otp_req;
    logic [1:0] otp_op;
    logic [`CFG_NUM_W-1:0] cfg_num, otp_num;
    logic apll_req, relock_sent, image_req, commit_req, cfg_loaded, upd_done;
    logic spi_mode, spi_4wire, serial_en, clk_oe, gpio_en, mon_en, alarm_en, busy;
    logic otp_err, otp_ok, ee_absent, ee_ok, upd_applied;
  } seq_s;

  seq_s r;
  seq_s n;
  logic ee_done_tgl;
  logic ee_found;
  logic ee_present;
  logic mr_rise;
  logic ee_done;
  logic strap_spi;
  logic scan_en;

  ////////////////////////////////////////////////////////////////////////////////

  // Packs the selected strap pins into a number, lowest pin first.
  function automatic logic [`CFG_NUM_W-1:0] cfg_number(
    input logic [`GPIO_W-1:0] straps,
    input logic [`GPIO_W-1:0] mask
  );
    logic [`CFG_NUM_W-1:0] v;
    logic [`GPIO_W-1:0] m;
    logic [2:0] k;
    v = '0;
    k = '0;
    m = (mask == '0) ? `CFG_DEF_MASK : mask;
    for (int i = 0; i < `GPIO_W; i++) begin
      if (m[i] && k < 3'(`CFG_NUM_W)) begin
        v[k[1:0]] = straps[i];
        k = k + 3'h1;
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  eeprom_search u_search (
    .link_clk(link_clk),
    .sys_rst(sys_rst),
    .start_tgl(r.start_tgl),
    .mode_config(r.ee_mode),
    .done_tgl(ee_done_tgl),
    .found(ee_found),
    .present(ee_present),
    .i2c_req(i2c_req),
    .i2c_kind(i2c_kind),
    .i2c_addr(i2c_addr),
    .i2c_speed(i2c_speed),
    .i2c_offset(i2c_offset),
    .i2c_done(i2c_done),
    .i2c_ack(i2c_ack),
    .i2c_valid(i2c_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////

  assign mr_rise = r.mr_s2 & ~r.mr_s3;
  assign ee_done = r.done_s2 ^ r.done_s3;
  assign strap_spi = r.straps[r.spi_idx];
  assign scan_en = r.straps[r.scan_idx] & ~strap_spi;

  always_comb begin
    n = r;
    n.mr_s1 = master_reset_n;
    n.mr_s2 = r.mr_s1;
    n.mr_s3 = r.mr_s2;
    n.tm_s1 = test_mode_n;
    n.tm_s2 = r.tm_s1;
    n.gpio_s1 = gpio_in;
    n.gpio_s2 = r.gpio_s1;
    n.done_s1 = ee_done_tgl;
    n.done_s2 = r.done_s1;
    n.done_s3 = r.done_s2;
    if (apll_done) begin
      n.apll_req = 1'b0;
    end
    if (mr_rise && r.tm_s2) begin
      n.straps = r.gpio_s2;
      n.edge_seen = 1'b1;
    end
    case (r.state)
      ST_START_INFO: begin
        n.otp_req = 1'b1;
        n.otp_op = `OTP_OP_INFO;
        if (r.otp_req && otp_done) begin
          n.otp_req = 1'b0;
          n.sel_mask = info_sel_mask;
          n.spi_idx = info_spi_idx;
          n.scan_idx = info_scan_idx;
          n.apll_req = 1'b1;
          n.state = ST_START_APLL;
        end
      end
      ST_START_APLL: begin
        if (apll_done) begin
          n.state = ST_WAIT_EDGE;
        end
      end
      ST_WAIT_EDGE: begin
        if (r.edge_seen) begin
          n.image_req = 1'b1;
          n.state = ST_IMAGE;
        end
      end
      ST_IMAGE: begin
        if (image_init_done) begin
          n.image_req = 1'b0;
          n.spi_mode = strap_spi;
          n.spi_4wire = strap_spi;
          n.cfg_num = cfg_number(r.straps, r.sel_mask);
          if (scan_en && !r.upd_done) begin
            n.ee_mode = 1'b0;
            n.start_tgl = ~r.start_tgl;
            n.state = ST_UPD_SCAN;
          end else begin
            n.otp_req = 1'b1;
            n.otp_op = `OTP_OP_CFG;
            n.state = ST_OTP_CFG;
          end
        end
      end
      ST_UPD_SCAN: begin
        if (ee_done) begin
          n.upd_done = 1'b1;
          n.ee_absent = ~ee_present;
          if (ee_found) begin
            n.upd_applied = 1'b1;
            n.state = ST_START_INFO;
          end else begin
            n.otp_req = 1'b1;
            n.otp_op = `OTP_OP_CFG;
            n.state = ST_OTP_CFG;
          end
        end
      end
      ST_OTP_CFG: begin
        if (otp_done) begin
          n.otp_req = 1'b0;
          if (otp_found && otp_csum_ok) begin
            n.otp_ok = 1'b1;
            n.otp_num = r.cfg_num;
            n.cfg_loaded = 1'b1;
            n.spi_mode = otp_sel_spi;
            n.spi_4wire = otp_sel_4wire;
            if (otp_sets_fbdiv) begin
              n.apll_req = 1'b1;
            end
          end else begin
            n.otp_err = 1'b1;
          end
          if (scan_en) begin
            n.ee_mode = 1'b1;
            n.start_tgl = ~r.start_tgl;
            n.state = ST_EE_CFG;
          end else begin
            n.otp_req = 1'b1;
            n.otp_op = `OTP_OP_HOTFIX;
            n.state = ST_HOTFIX;
          end
        end
      end
      ST_EE_CFG: begin
        if (ee_done) begin
          n.ee_absent = ~ee_present;
          if (ee_found) begin
            n.ee_ok = 1'b1;
            n.cfg_loaded = 1'b1;
          end
          n.otp_req = 1'b1;
          n.otp_op = `OTP_OP_HOTFIX;
          n.state = ST_HOTFIX;
        end
      end
      ST_HOTFIX: begin
        if (otp_done) begin
          n.otp_req = 1'b0;
          n.relock_sent = 1'b0;
          n.state = r.cfg_loaded ? ST_RELOCK : ST_COMMIT;
          n.serial_en = ~r.cfg_loaded;
          n.commit_req = ~r.cfg_loaded;
        end
      end
      ST_RELOCK: begin
        if (!r.relock_sent && !r.apll_req) begin
          n.apll_req = 1'b1;
          n.relock_sent = 1'b1;
        end else if (r.relock_sent && apll_done) begin
          n.serial_en = 1'b1;
          n.commit_req = 1'b1;
          n.state = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        if (commit_done) begin
          n.commit_req = 1'b0;
          n.clk_oe = 1'b1;
          n.gpio_en = 1'b1;
          n.state = ST_MONITORS;
        end
      end
      ST_MONITORS: begin
        n.mon_en = 1'b1;
        n.state = ST_ALARMS;
      end
      ST_ALARMS: begin
        n.alarm_en = 1'b1;
        n.busy = 1'b0;
        n.state = ST_RUN;
      end
      ST_RUN: begin
        n.busy = 1'b0;
      end
      default: begin
        n.state = ST_START_INFO;
      end
    endcase
    if (!r.mr_s2) begin
      n.edge_seen = 1'b0;
      n.upd_done = 1'b0;
      n.busy = 1'b1;
      n.serial_en = 1'b0;
      n.clk_oe = 1'b0;
      n.gpio_en = 1'b0;
      n.mon_en = 1'b0;
      n.alarm_en = 1'b0;
      n.image_req = 1'b0;
      n.commit_req = 1'b0;
      if (r.state != ST_START_INFO && r.state != ST_START_APLL && r.state != ST_WAIT_EDGE) begin
        n.otp_req = 1'b0;
        n.cfg_loaded = 1'b0;
        n.otp_err = 1'b0;
        n.otp_ok = 1'b0;
        n.ee_absent = 1'b0;
        n.ee_ok = 1'b0;
        n.upd_applied = 1'b0;
        n.state = ST_START_INFO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{state: ST_START_INFO, busy: 1'b1, otp_op: `OTP_OP_INFO, default: '0};
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign otp_req = r.otp_req;
  assign otp_op = r.otp_op;
  assign otp_cfg_num = r.cfg_num;
  assign apll_cal_req = r.apll_req;
  assign image_init_req = r.image_req;
  assign commit_req = r.commit_req;
  assign clock_outputs_oe = r.clk_oe;
  assign clock_outputs_inv_oe = r.clk_oe;
  assign gpio_out_en = r.gpio_en;
  assign serial_en = r.serial_en;
  assign serial_spi_mode = r.spi_mode;
  assign serial_spi_4wire = r.spi_4wire;
  assign monitors_en = r.mon_en;
  assign alarms_en = r.alarm_en;
  assign seq_busy = r.busy;
  assign otp_cfg_err = r.otp_err;
  assign otp_cfg_loaded = r.otp_ok;
  assign otp_cfg_loaded_num = r.otp_num;
  assign eeprom_absent = r.ee_absent;
  assign eeprom_cfg_loaded = r.ee_ok;
  assign eeprom_update_applied = r.upd_applied;

endmodule

//--- verilog/reset_config_defs.svh
`ifndef RESET_CONFIG_DEFS_SVH
`define RESET_CONFIG_DEFS_SVH

// Widths of the strap capture and the configuration number.
`define GPIO_W 16
`define CFG_NUM_W 4
`define IDX_W 4
`define CFG_DEF_MASK 16'h000F

// Memory load operations requested from the one-time memory controller.
`define OTP_OP_INFO 2'h0
`define OTP_OP_CFG 2'h1
`define OTP_OP_HOTFIX 2'h2

// EEPROM bus addresses, block offsets and probe speeds.
`define EE_ADDR_FIRST 7'h50
`define EE_ADDR_LAST 7'h57
`define EE_OFS_LOW 16'h0000
`define EE_OFS_HIGH 16'hF000
`define SPD_1M 2'h0
`define SPD_400K 2'h1
`define SPD_100K 2'h2

// Kinds of transfer requested from the I2C master.
`define KIND_PROBE 2'h0
`define KIND_UPDATE 2'h1
`define KIND_CONFIG 2'h2

`endif

//--- verilog/reset_config_pkg.sv
`include "reset_config_defs.svh"

package reset_config_pkg;

  typedef enum logic [3:0] {
    ST_START_INFO,
    ST_START_APLL,
    ST_WAIT_EDGE,
    ST_IMAGE,
    ST_UPD_SCAN,
    ST_OTP_CFG,
    ST_EE_CFG,
    ST_HOTFIX,
    ST_RELOCK,
    ST_COMMIT,
    ST_MONITORS,
    ST_ALARMS,
    ST_RUN
  } seq_state_e;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_PROBE,
    LS_BLOCK,
    LS_NEXT,
    LS_REPORT
  } link_state_e;

  typedef struct packed {
    link_state_e state;
    logic start_s1;
    logic start_s2;
    logic start_s3;
    logic mode_config;
    logic [6:0] addr;
    logic [1:0] speed;
    logic [15:0] offset;
    logic any_present;
    logic found;
    logic present;
    logic done_tgl;
    logic req;
    logic [1:0] kind;
  } link_s;

endpackage

//--- verilog/eeprom_search.sv
`include "reset_config_defs.svh"

module eeprom_search
  import reset_config_pkg::*;
(
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic start_tgl,
  input wire logic mode_config,
  output logic done_tgl,
  output logic found,
  output logic present,
  output logic i2c_req,
  output logic [1:0] i2c_kind,
  output logic [6:0] i2c_addr,
  output logic [1:0] i2c_speed,
  output logic [15:0] i2c_offset,
  input wire logic i2c_done,
  input wire logic i2c_ack,
  input wire logic i2c_valid
);

  link_s r;
  link_s n;

  always_comb begin
    n = r;
    n.start_s1 = start_tgl;
    n.start_s2 = r.start_s1;
    n.start_s3 = r.start_s2;
    case (r.state)
      LS_IDLE: begin
        if (r.start_s2 != r.start_s3) begin
          n.mode_config = mode_config;
          n.addr = `EE_ADDR_FIRST;
          n.speed = `SPD_1M;
          n.any_present = 1'b0;
          n.found = 1'b0;
          n.present = 1'b0;
          n.req = 1'b1;
          n.kind = `KIND_PROBE;
          n.state = LS_PROBE;
        end
      end
      LS_PROBE: begin
        if (i2c_done) begin
          n.req = 1'b0;
          n.state = LS_NEXT;
          if (i2c_ack) begin
            n.any_present = 1'b1;
            n.present = 1'b1;
            n.offset = `EE_OFS_LOW;
            n.req = 1'b1;
            n.kind = r.mode_config ? `KIND_CONFIG : `KIND_UPDATE;
            n.state = LS_BLOCK;
          end
        end
      end
      LS_BLOCK: begin
        if (i2c_done) begin
          n.req = 1'b0;
          if (i2c_valid) begin
            n.found = 1'b1;
            n.state = LS_REPORT;
          end else if (r.mode_config && r.offset == `EE_OFS_LOW) begin
            n.offset = `EE_OFS_HIGH;
            n.req = 1'b1;
          end else begin
            n.state = LS_NEXT;
          end
        end
      end
      LS_NEXT: begin
        n.kind = `KIND_PROBE;
        if (r.addr == `EE_ADDR_LAST) begin
          if (r.any_present || r.speed == `SPD_100K) begin
            n.state = LS_REPORT;
          end else begin
            n.speed = r.speed + 2'h1;
            n.addr = `EE_ADDR_FIRST;
            n.req = 1'b1;
            n.state = LS_PROBE;
          end
        end else begin
          n.addr = r.addr + 7'h01;
          n.req = 1'b1;
          n.state = LS_PROBE;
        end
      end
      LS_REPORT: begin
        n.done_tgl = ~r.done_tgl;
        n.state = LS_IDLE;
      end
      default: begin
        n.state = LS_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{state: LS_IDLE, addr: `EE_ADDR_FIRST, speed: `SPD_1M, offset: `EE_OFS_LOW,
             kind: `KIND_PROBE, default: '0};
    end else begin
      r <= n;
    end
  end

  assign done_tgl = r.done_tgl;
  assign found = r.found;
  assign present = r.present;
  assign i2c_req = r.req;
  assign i2c_kind = r.kind;
  assign i2c_addr = r.addr;
  assign i2c_speed = r.speed;
  assign i2c_offset = r.offset;

endmodule

//--- sim/reset_config_loader_asserts.sv
`include "reset_config_defs.svh"

module reset_config_loader_asserts (
  input logic mclk,
  input logic sys_rst,
  input logic master_reset_n,
  input logic clock_outputs_oe,
  input logic clock_outputs_inv_oe,
  input logic gpio_out_en,
  input logic serial_en,
  input logic commit_req,
  input logic monitors_en,
  input logic alarms_en,
  input logic seq_busy,
  input logic apll_done,
  input logic otp_cfg_loaded,
  input logic eeprom_cfg_loaded,
  input logic link_clk,
  input logic i2c_req,
  input logic i2c_done,
  input logic [1:0] i2c_kind,
  input logic [6:0] i2c_addr,
  input logic [1:0] i2c_speed,
  input logic [15:0] i2c_offset
);
  // Monitors start one cycle after outputs, alarms one cycle later.
  sequence s_tail;
    monitors_en && !alarms_en ##1 alarms_en && !seq_busy;
  endsequence
  sequence s_oe_start;
    $rose(clock_outputs_oe) && !monitors_en;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_pins_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    !serial_en |-> !clock_outputs_oe && !clock_outputs_inv_oe && !gpio_out_en)
    else $error("pins enabled before serial port");
  chk_reset_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    !master_reset_n [*5] |-> !serial_en && !clock_outputs_oe && !alarms_en && seq_busy)
    else $error("device active while held in reset");
  chk_enable_order: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(clock_outputs_oe) |-> s_oe_start ##1 s_tail)
    else $error("completion steps out of order");
  chk_serial_first: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(commit_req) |-> serial_en)
    else $error("commit before serial port enable");
  chk_relock_first: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(commit_req) && (otp_cfg_loaded || eeprom_cfg_loaded) |-> $past(apll_done))
    else $error("commit without relock");
  chk_busy_alarms: assert property (@(posedge mclk) disable iff (sys_rst)
    alarms_en |-> !seq_busy)
    else $error("alarms on while busy");
  chk_block_offset: assert property (@(posedge link_clk) disable iff (sys_rst)
    i2c_req && i2c_kind != `KIND_PROBE |-> i2c_offset inside {`EE_OFS_LOW, `EE_OFS_HIGH})
    else $error("block read at odd offset");
  chk_probe_range: assert property (@(posedge link_clk) disable iff (sys_rst)
    i2c_req |-> i2c_addr inside {[`EE_ADDR_FIRST:`EE_ADDR_LAST]} && i2c_speed <= `SPD_100K)
    else $error("address or speed out of range");
  chk_req_hold: assert property (@(posedge link_clk) disable iff (sys_rst)
    i2c_req && !i2c_done |=> i2c_req && $stable({i2c_kind, i2c_addr, i2c_speed, i2c_offset}))
    else $error("link request changed before answer");
endmodule

bind reset_config_loader reset_config_loader_asserts i_reset_config_loader_asserts (.*);

//--- sim/cfg_partner.sv
`include "reset_config_defs.svh"

module cfg_partner (
  input logic mclk,
  input logic sys_rst,
  input logic link_clk,
  input logic otp_req,
  input logic apll_cal_req,
  input logic image_init_req,
  input logic commit_req,
  output logic otp_done,
  output logic apll_done,
  output logic image_init_done,
  output logic commit_done,
  input logic i2c_req,
  input logic [1:0] i2c_kind,
  input logic [6:0] i2c_addr,
  input logic [1:0] i2c_speed,
  input logic [15:0] i2c_offset,
  output logic i2c_done,
  output logic i2c_ack,
  output logic i2c_valid,
  input logic [6:0] ack_addr,
  input logic [1:0] ack_spd,
  input logic upd_ok,
  input logic cfg_ok,
  input logic [15:0] ok_ofs
);
  logic [3:0] rq, dn;
  logic [3:0][1:0] cnt;
  logic [1:0] lc;
  logic tg;
  assign rq = {commit_req, image_init_req, apll_cal_req, otp_req};
  assign {commit_done, image_init_done, apll_done, otp_done} = dn;
  // Each responder has its own latency, from prompt to slow.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
      dn <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        dn[i] <= rq[i] && !dn[i] && cnt[i] == 2'(i);
        cnt[i] <= (rq[i] && !dn[i]) ? cnt[i] + 2'h1 : 2'h0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lc <= '0;
      tg <= '0;
      i2c_done <= '0;
    end else begin
      tg <= !tg;
      i2c_done <= i2c_req && !i2c_done && lc == 2'h3;
      lc <= (i2c_req && !i2c_done) ? lc + 2'h1 : 2'h0;
    end
  end
  // Outside an answer the status lines toggle, so a stale level is never valid.
  assign i2c_ack = i2c_done ? (i2c_kind == `KIND_PROBE && i2c_addr == ack_addr
    && i2c_speed >= ack_spd) : tg;
  assign i2c_valid = i2c_done ? (i2c_kind != `KIND_PROBE && i2c_addr == ack_addr
    && i2c_offset == ok_ofs && (i2c_kind == `KIND_UPDATE ? upd_ok : cfg_ok)) : !tg;
endmodule

//--- sim/tb.sv
`include "reset_config_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = '0, link_clk = '0, sys_rst = '1, clk_en = '1, master_reset_n = '0, test_mode_n = '1;
  logic [15:0] gpio_in = '0, info_sel_mask = '0, ok_ofs = '0;
  logic [3:0] info_spi_idx = 4'hC, info_scan_idx = 4'hD;
  logic otp_found = '0, otp_csum_ok = '0, otp_sets_fbdiv = '0, otp_sel_spi = '0, otp_sel_4wire = '1;
  logic [6:0] ack_addr = 7'h7F;
  logic [1:0] ack_spd = 2'h0;
  logic upd_ok = '0, cfg_ok = '0;
  logic otp_req, otp_done, apll_cal_req, apll_done, image_init_req, image_init_done, commit_req;
  logic commit_done, clock_outputs_oe, clock_outputs_inv_oe, gpio_out_en, serial_en, alarms_en;
  logic serial_spi_mode, serial_spi_4wire, monitors_en, seq_busy, otp_cfg_err, otp_cfg_loaded;
  logic eeprom_absent, eeprom_cfg_loaded, eeprom_update_applied, i2c_req, i2c_done, i2c_ack, i2c_valid;
  logic [1:0] otp_op, i2c_kind, i2c_speed, last_spd;
  logic [3:0] otp_cfg_num, otp_cfg_loaded_num, num_seen;
  logic [6:0] i2c_addr;
  logic [15:0] i2c_offset;
  logic [8:0] first_probe;
  logic got_cfg, cal_q, info_q, img_ok;
  int errors = 0, check_count = 0, probes, bad_ofs, cfg_after, cal_cnt, info_cnt, hot_cnt;

  reset_config_loader i_reset_config_loader (.*);
  cfg_partner i_cfg_partner (.*);

  initial forever #50 mclk = ~mclk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (otp_req && otp_op == `OTP_OP_CFG) num_seen <= otp_cfg_num;
    if (apll_cal_req && !cal_q) cal_cnt++;
    if (otp_req && otp_op == `OTP_OP_INFO && !info_q) info_cnt++;
    cal_q <= apll_cal_req;
    info_q <= otp_req && otp_op == `OTP_OP_INFO;
    if (otp_req && otp_done && otp_op == `OTP_OP_HOTFIX) hot_cnt++;
    if (image_init_req) img_ok <= !clock_outputs_oe && !gpio_out_en && !serial_en;
  end
  always @(posedge link_clk) begin
    if (i2c_req && i2c_done && i2c_kind == `KIND_PROBE) begin
      probes++;
      last_spd = i2c_speed;
      if (probes == 1) first_probe = {i2c_addr, i2c_speed};
    end else if (i2c_req && i2c_done) begin
      if (!(i2c_offset inside {`EE_OFS_LOW, `EE_OFS_HIGH})) bad_ofs++;
      if (i2c_kind == `KIND_CONFIG && got_cfg) cfg_after++;
      if (i2c_kind == `KIND_CONFIG && i2c_valid) got_cfg = '1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'h1) begin
      errors++;
      $display("ERROR at %0t: %s", $time, m);
    end
  endtask
  // Pulses the reset pin with the straps set, then waits for completion.
  task automatic boot(input logic [15:0] g);
    int n;
    master_reset_n = '0;
    gpio_in = g;
    {probes, bad_ofs, cfg_after, cal_cnt, info_cnt, hot_cnt, got_cfg, img_ok} = '0;
    repeat (40) @(negedge mclk);
    chk(seq_busy === '1 && clock_outputs_oe === '0 && serial_en === '0, "active in reset");
    master_reset_n = '1;
    repeat (6) @(negedge mclk);
    gpio_in = ~g;
    n = 0;
    while (seq_busy !== 1'h0 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20000) begin
      errors++;
      $display("ERROR at %0t: sequence hung", $time);
      close_out;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_test_mode;
    test_mode_n = '0;
    master_reset_n = '0;
    repeat (40) @(negedge mclk);
    master_reset_n = '1;
    repeat (80) @(negedge mclk);
    chk(seq_busy === '1 && image_init_req === '0 && serial_en === '0, "ran in test mode");
    test_mode_n = '1;
    $display("test mode case done");
  endtask
  task automatic t_otp_cfg;
    otp_found = '1;
    otp_csum_ok = '1;
    otp_sets_fbdiv = '1;
    boot(16'h3006);
    chk(num_seen === 4'h6, "number not from captured straps");
    chk(otp_cfg_loaded === '1 && otp_cfg_loaded_num === 4'h6 && otp_cfg_err === '0, "status");
    chk(probes == 0, "eeprom searched in spi mode");
    chk(serial_spi_mode === '0, "protocol not from loaded registers");
    chk(cal_cnt >= 2, "no apll relock");
    chk(monitors_en === '1 && alarms_en === '1 && gpio_out_en === '1, "not running");
    $display("memory config case done");
  endtask
  task automatic t_mask;
    otp_found = '0;
    info_sel_mask = 16'h0234;
    boot(16'h3214);
    chk(num_seen === 4'hB, "selected pin order");
    chk(info_cnt == 1, "no info block load");
    chk(img_ok === '1, "pins moved while building image");
    chk(otp_cfg_err === '1 && otp_cfg_loaded === '0, "missing config status");
    chk(serial_spi_mode === '1 && serial_spi_4wire === '1, "spi strap mode");
    chk(cal_cnt == 1 && probes == 0 && alarms_en === '1, "default run");
    $display("pin select case done");
  endtask
  task automatic t_ee_cfg;
    otp_found = '1;
    otp_csum_ok = '0;
    info_sel_mask = 16'h0006;
    ack_addr = 7'h53;
    ack_spd = 2'h1;
    cfg_ok = '1;
    ok_ofs = 16'hF000;
    boot(16'h200E);
    chk(num_seen === 4'h3, "zero fill of number");
    chk(otp_cfg_err === '1 && eeprom_cfg_loaded === '1 && eeprom_absent === '0, "status");
    chk(first_probe === {`EE_ADDR_FIRST, `SPD_1M}, "first probe");
    chk(bad_ofs == 0 && cfg_after == 0 && info_cnt == 1, "block search");
    chk(cal_cnt >= 2, "no relock after eeprom config");
    chk(hot_cnt == 1, "hotfix step not run once");
    $display("eeprom config case done");
  endtask
  task automatic t_ee_absent;
    otp_found = '0;
    info_sel_mask = '0;
    ack_addr = 7'h7F;
    boot(16'h2000);
    chk(eeprom_absent === '1 && eeprom_cfg_loaded === '0 && alarms_en === '1, "absent");
    chk(probes > 0 && probes % 24 == 0 && last_spd === `SPD_100K, "probe sweep");
    chk(cal_cnt == 1, "relock without config");
    $display("no eeprom case done");
  endtask
  task automatic t_update;
    ack_addr = 7'h50;
    ack_spd = 2'h0;
    upd_ok = '1;
    cfg_ok = '0;
    ok_ofs = 16'h0000;
    boot(16'h2000);
    chk(info_cnt == 2 && eeprom_update_applied === '1, "update restart");
    chk(eeprom_cfg_loaded === '0 && alarms_en === '1, "bad config accepted");
    $display("update case done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge mclk);
    chk(seq_busy === '1 && alarms_en === '0 && i2c_addr === `EE_ADDR_FIRST, "reset values");
    sys_rst = '0;
    t_test_mode;
    t_otp_cfg;
    t_mask;
    t_ee_cfg;
    t_ee_absent;
    t_update;
    close_out;
  end
endmodule
